// [design/multi_channel_pwm_generator.v]
// Purpose: ten-output PWM unit plus shared drive channel, AXI4-Lite registers
// Assumes: one clock mclk (10 MHz), asynchronous active-low reset_n
// Notes: all top outputs are registered
//
// Summary of operation
// - Eleven channels, each a 16-bit down counter auto-reloading from its period.
// - Whole unit runs from the bus clock only.
// - Eleven prescalers, one per channel, each with a 10-bit setting.
// - Prescaler tick rate is clock rate divided by setting plus one.
// - Counter runs period down to zero, giving period plus one ticks.
// - Period, compare and polarity take effect at the end of a period.
// - Output changes on decrement after compare, holds from compare-1 to zero.
// - Polarity low drives high on match; polarity high drives low.
// - A disabled channel outputs its own disabled-state level.
// - Shared channel has no disabled level; outputs follow own channels then.
// - Shared channel enabled drives all ten outputs with its waveform.
// - Eleven overflow interrupt outputs, one per channel.
// - Overflow pending flags readable across three status registers.
// - Writing one clears a pending flag; writing zero leaves it.
// - Each overflow interrupt is gated by its own enable bit.
// - Outputs eight and nine also drive converter sequencer triggers.
// - Outputs start from a defined level after reset and at start.
`timescale 1ns/10ps
`include "pwm_regs.vh"

module multi_channel_pwm_generator #(
  parameter NOUT = 10,
  parameter CNT_W = 16,
  parameter PSC_W = 10
) (
  input wire mclk,
  input wire reset_n,
  input wire [`PWM_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`PWM_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [NOUT-1:0] pwmOut,
  output reg convTrigA,
  output reg convTrigB,
  output reg [NOUT:0] ovfIrq,
  output reg irqAny
);

  localparam NCH = NOUT + 1;
  localparam SH = NOUT;

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  reg [NCH-1:0] chanEn_reg;
  reg [NCH-1:0] irqEn_reg;
  reg [NCH-1:0] pend_reg;
  reg [NCH-1:0] pend_next;
  reg [PSC_W-1:0] pscl_reg [0:NCH-1];
  reg [CNT_W-1:0] period_reg [0:NCH-1];
  reg [CNT_W-1:0] cmp_reg [0:NCH-1];
  reg [NCH-1:0] pol_reg;
  reg [NCH-1:0] disLvl_reg;

  wire [NCH-1:0] chanOut;
  wire [NCH-1:0] ovfPulse;
  reg [NCH-1:0] clrMask;
  reg [NOUT-1:0] pwmOut_next;
  reg [31:0] rdData;
  reg [31:0] wrOld;
  reg [31:0] wrMerged;
  reg rdOk;
  wire wrFire;
  wire rdFire;
  integer i;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Byte-lane merge of a write into an old word
  function [31:0] strobeMerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      strobeMerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          strobeMerge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  // True if the address lies in a channel block
  function isChan;
    input [`PWM_ADDR_W-1:0] a;
    begin
      isChan = (a[7:4] >= `PWM_CH_FIRST) && (a[7:4] <= `PWM_CH_LAST);
    end
  endfunction

  // Channel index of a channel-block address
  function [3:0] chanIdx;
    input [`PWM_ADDR_W-1:0] a;
    begin
      chanIdx = a[7:4] - `PWM_CH_FIRST;
    end
  endfunction

  // Address is a mapped register
  function isMapped;
    input [`PWM_ADDR_W-1:0] a;
    begin
      isMapped = (a[1:0] == 2'b00) && (isChan(a)
        || (a == `PWM_CTRL_OFS) || (a == `PWM_PEND0_OFS)
        || (a == `PWM_PEND1_OFS) || (a == `PWM_PEND2_OFS)
        || (a == `PWM_OUTSTAT_OFS));
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Channel instances
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      pwm_channel #(
        .CNT_W(CNT_W),
        .PSC_W(PSC_W)
      ) u_chan (
        .mclk(mclk),
        .reset_n(reset_n),
        .enable(chanEn_reg[g]),
        .pscl(pscl_reg[g]),
        .period(period_reg[g]),
        .cmpBuf(cmp_reg[g]),
        .polBuf(pol_reg[g]),
        .disLevel(disLvl_reg[g]),
        .out(chanOut[g]),
        .ovfPulse(ovfPulse[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // AXI4-Lite handshake
  // ---------------------------------------------------------------------------
  // Address and data are taken together, so no half-written state exists
  assign wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign rdFire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  // Write channel: ready pulses one cycle, response raised in the same cycle
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PWM_RESP_OKAY;
    end else begin
      s_axi_awready <= wrFire;
      s_axi_wready <= wrFire;
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= isMapped(s_axi_awaddr) ? `PWM_RESP_OKAY : `PWM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PWM_RESP_OKAY;
    end else begin
      s_axi_arready <= rdFire;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdData;
        s_axi_rresp <= rdOk ? `PWM_RESP_OKAY : `PWM_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  // Unmapped addresses read zero with an error response
  always @* begin
    rdData = 32'h0000_0000;
    rdOk = isMapped(s_axi_araddr);
    if (rdOk && isChan(s_axi_araddr)) begin
      case (s_axi_araddr[3:2])
        `PWM_FLD_PSCL: rdData[PSC_W-1:0] = pscl_reg[chanIdx(s_axi_araddr)];
        `PWM_FLD_PERIOD: rdData[CNT_W-1:0] = period_reg[chanIdx(s_axi_araddr)];
        `PWM_FLD_CMP: rdData[CNT_W-1:0] = cmp_reg[chanIdx(s_axi_araddr)];
        default: begin
          rdData[`PWM_CFG_POL] = pol_reg[chanIdx(s_axi_araddr)];
          rdData[`PWM_CFG_DISLVL] = disLvl_reg[chanIdx(s_axi_araddr)];
        end
      endcase
    end else if (rdOk) begin
      case (s_axi_araddr)
        `PWM_CTRL_OFS: begin
          rdData[`PWM_CTRL_EN_LSB +: NCH] = chanEn_reg;
          rdData[`PWM_CTRL_IE_LSB +: NCH] = irqEn_reg;
        end
        `PWM_PEND0_OFS: rdData[`PWM_PEND1_BASE-1:0] = pend_reg[`PWM_PEND1_BASE-1:0];
        `PWM_PEND1_OFS: begin
          rdData[`PWM_PEND2_BASE-`PWM_PEND1_BASE-1:0] =
            pend_reg[`PWM_PEND2_BASE-1:`PWM_PEND1_BASE];
        end
        `PWM_PEND2_OFS: begin
          rdData[NCH-`PWM_PEND2_BASE-1:0] = pend_reg[NCH-1:`PWM_PEND2_BASE];
        end
        default: rdData[NCH-1:0] = {chanOut[SH], pwmOut};
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration writes
  // ---------------------------------------------------------------------------
  // Old field value widened to a word, so lanes merge without silent truncation
  always @* begin
    wrOld = 32'h0000_0000;
    case (s_axi_awaddr[3:2])
      `PWM_FLD_PSCL: wrOld[PSC_W-1:0] = pscl_reg[chanIdx(s_axi_awaddr)];
      `PWM_FLD_PERIOD: wrOld[CNT_W-1:0] = period_reg[chanIdx(s_axi_awaddr)];
      default: wrOld[CNT_W-1:0] = cmp_reg[chanIdx(s_axi_awaddr)];
    endcase
    wrMerged = strobeMerge(wrOld, s_axi_wdata, s_axi_wstrb);
  end

  // Writes land in buffers; channels pick up period, compare and polarity at period end
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chanEn_reg <= {NCH{1'b0}};
      irqEn_reg <= {NCH{1'b0}};
      pol_reg <= {NCH{1'b0}};
      disLvl_reg <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        pscl_reg[i] <= `PWM_PSCL_RST;
        period_reg[i] <= `PWM_PERIOD_RST;
        cmp_reg[i] <= `PWM_CMP_RST;
      end
    end else if (wrFire && isMapped(s_axi_awaddr)) begin
      if (isChan(s_axi_awaddr)) begin
        case (s_axi_awaddr[3:2])
          `PWM_FLD_PSCL: pscl_reg[chanIdx(s_axi_awaddr)] <= wrMerged[PSC_W-1:0];
          `PWM_FLD_PERIOD: period_reg[chanIdx(s_axi_awaddr)] <= wrMerged[CNT_W-1:0];
          `PWM_FLD_CMP: cmp_reg[chanIdx(s_axi_awaddr)] <= wrMerged[CNT_W-1:0];
          default: begin
            if (s_axi_wstrb[0]) begin
              pol_reg[chanIdx(s_axi_awaddr)] <= s_axi_wdata[`PWM_CFG_POL];
              // Shared channel keeps no disabled level
              if (chanIdx(s_axi_awaddr) != SH) begin
                disLvl_reg[chanIdx(s_axi_awaddr)] <= s_axi_wdata[`PWM_CFG_DISLVL];
              end
            end
          end
        endcase
      end else if (s_axi_awaddr == `PWM_CTRL_OFS) begin
        if (s_axi_wstrb[0]) begin
          chanEn_reg[7:0] <= s_axi_wdata[7:0];
        end
        if (s_axi_wstrb[1]) begin
          chanEn_reg[NCH-1:8] <= s_axi_wdata[NCH-1:8];
        end
        if (s_axi_wstrb[2]) begin
          irqEn_reg[7:0] <= s_axi_wdata[23:16];
        end
        if (s_axi_wstrb[3]) begin
          irqEn_reg[NCH-1:8] <= s_axi_wdata[`PWM_CTRL_IE_LSB+NCH-1:24];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pending flags
  // ---------------------------------------------------------------------------
  // Clear mask from a write-one to one of the three status words
  always @* begin
    clrMask = {NCH{1'b0}};
    if (wrFire && s_axi_wstrb[0]) begin
      case (s_axi_awaddr)
        `PWM_PEND0_OFS: clrMask[`PWM_PEND1_BASE-1:0] =
          s_axi_wdata[`PWM_PEND1_BASE-1:0];
        `PWM_PEND1_OFS: clrMask[`PWM_PEND2_BASE-1:`PWM_PEND1_BASE] =
          s_axi_wdata[`PWM_PEND2_BASE-`PWM_PEND1_BASE-1:0];
        `PWM_PEND2_OFS: clrMask[NCH-1:`PWM_PEND2_BASE] =
          s_axi_wdata[NCH-`PWM_PEND2_BASE-1:0];
        default: clrMask = {NCH{1'b0}};
      endcase
    end
    // A reload in the clearing cycle still leaves the flag set
    pend_next = (pend_reg & ~clrMask) | ovfPulse;
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pend_reg <= {NCH{1'b0}};
    end else begin
      pend_reg <= pend_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------------------
  // Shared channel, when running, overrides every output
  always @* begin
    if (chanEn_reg[SH]) begin
      pwmOut_next = {NOUT{chanOut[SH]}};
    end else begin
      pwmOut_next = chanOut[NOUT-1:0];
    end
  end

  // One register stage on every pin; adds a clock of latency to all equally
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pwmOut <= {NOUT{1'b0}};
      convTrigA <= 1'b0;
      convTrigB <= 1'b0;
      ovfIrq <= {NCH{1'b0}};
      irqAny <= 1'b0;
    end else begin
      pwmOut <= pwmOut_next;
      convTrigA <= pwmOut_next[8];
      convTrigB <= pwmOut_next[9];
      ovfIrq <= pend_next & irqEn_reg;
      irqAny <= |(pend_next & irqEn_reg);
    end
  end

endmodule // multi_channel_pwm_generator

// [design/pwm_regs.vh]
// Purpose: register offsets, field positions and reset values of the PWM unit
// Assumes: included by the PWM design files by its bare name
// Notes: definitions only
`ifndef PWM_REGS_VH
`define PWM_REGS_VH

// ----------------------------------------------------------------------------
// Global registers
// ----------------------------------------------------------------------------
`define PWM_ADDR_W 8
`define PWM_CTRL_OFS 8'h00
`define PWM_PEND0_OFS 8'h04
`define PWM_PEND1_OFS 8'h08
`define PWM_PEND2_OFS 8'h0C
`define PWM_OUTSTAT_OFS 8'hC0

// Channel enables in CTRL bits 10:0, interrupt enables in bits 26:16
`define PWM_CTRL_EN_LSB 0
`define PWM_CTRL_IE_LSB 16

// Pending split: reg0 holds 0..3, reg1 4..7, reg2 8..10
`define PWM_PEND1_BASE 4
`define PWM_PEND2_BASE 8

// ----------------------------------------------------------------------------
// Per-channel block: base 0x10, stride 0x10, channel index = addr[7:4] - 1
// ----------------------------------------------------------------------------
`define PWM_CH_FIRST 4'h1
`define PWM_CH_LAST 4'hB
`define PWM_FLD_PSCL 2'h0
`define PWM_FLD_PERIOD 2'h1
`define PWM_FLD_CMP 2'h2
`define PWM_FLD_CFG 2'h3
`define PWM_CFG_POL 0
`define PWM_CFG_DISLVL 1

// Reset values
`define PWM_PSCL_RST 10'h000
`define PWM_PERIOD_RST 16'hFFFF
`define PWM_CMP_RST 16'h0000

// AXI responses
`define PWM_RESP_OKAY 2'b00
`define PWM_RESP_SLVERR 2'b10

`endif

// [design/pwm_channel.v]
// Purpose: one PWM channel: prescaler, down counter, shadowed compare/polarity
// Assumes: single clock mclk, asynchronous active-low reset
// Notes: out is registered; ovfPulse is a one-cycle pulse at each reload
`timescale 1ns/10ps
`include "pwm_regs.vh"

module pwm_channel #(
  parameter CNT_W = 16,
  parameter PSC_W = 10
) (
  input wire mclk,
  input wire reset_n,
  input wire enable,
  input wire [PSC_W-1:0] pscl,
  input wire [CNT_W-1:0] period,
  input wire [CNT_W-1:0] cmpBuf,
  input wire polBuf,
  input wire disLevel,
  output reg out,
  output reg ovfPulse
);

  reg [PSC_W-1:0] pscCnt_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cmpSh_reg;
  reg polSh_reg;
  reg run_reg;
  wire tick;

  // ---------------------------------------------------------------------------
  // Prescaler: one tick every pscl+1 clocks
  // ---------------------------------------------------------------------------
  assign tick = run_reg && (pscCnt_reg == pscl);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pscCnt_reg <= {PSC_W{1'b0}};
    end else if (!run_reg || tick) begin
      pscCnt_reg <= {PSC_W{1'b0}};
    end else begin
      pscCnt_reg <= pscCnt_reg + {{(PSC_W-1){1'b0}}, 1'b1};
    end
  end

  // ---------------------------------------------------------------------------
  // Counter and waveform
  // ---------------------------------------------------------------------------
  // Shadows follow buffers while stopped so a start uses fresh settings
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= `PWM_PERIOD_RST;
      cmpSh_reg <= `PWM_CMP_RST;
      polSh_reg <= 1'b0;
      run_reg <= 1'b0;
      out <= 1'b0;
      ovfPulse <= 1'b0;
    end else begin
      ovfPulse <= 1'b0;
      if (!enable) begin
        run_reg <= 1'b0;
        out <= disLevel;
        cnt_reg <= period;
        cmpSh_reg <= cmpBuf;
        polSh_reg <= polBuf;
      end else if (!run_reg) begin
        // Start from the unmatched level, never from a stale one
        run_reg <= 1'b1;
        out <= polSh_reg;
      end else if (tick) begin
        if (cnt_reg == {CNT_W{1'b0}}) begin
          cnt_reg <= period;
          cmpSh_reg <= cmpBuf;
          polSh_reg <= polBuf;
          out <= polBuf;
          ovfPulse <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
          if (cnt_reg == cmpSh_reg) begin
            out <= ~polSh_reg;
          end
        end
      end
    end
  end

endmodule // pwm_channel

// [dv/conv_seq_model.sv]
// Purpose: converter sequencer stand-in that counts PWM trigger events
// Assumes: triggers are sampled on mclk
// Notes: passive load, it never drives the unit
`timescale 1ns/10ps
module conv_seq_model (
  input wire mclk,
  input wire reset_n,
  input wire convTrigA,
  input wire convTrigB,
  output int trigCntA,
  output int trigCntB
);
  logic lastA;
  logic lastB;
  // ------------------------------------------------------------
  // Trigger edge counting
  // ------------------------------------------------------------
  // Rising edges only, a level reading would count a pulse many times
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lastA <= 1'b0;
      lastB <= 1'b0;
      trigCntA <= 0;
      trigCntB <= 0;
    end else begin
      lastA <= convTrigA;
      lastB <= convTrigB;
      trigCntA <= trigCntA + (convTrigA && !lastA);
      trigCntB <= trigCntB + (convTrigB && !lastB);
    end
  end
endmodule // conv_seq_model

// [dv/pwm_gen_properties.sv]
// Purpose: port-level checks of the PWM unit
// Assumes: bound to multi_channel_pwm_generator, one clock domain
// Notes: internal registers are hidden, so relations use ports only
`timescale 1ns/10ps
module pwm_gen_properties #(
  parameter NOUT = 10
) (
  input wire mclk,
  input wire reset_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NOUT-1:0] pwmOut,
  input wire convTrigA,
  input wire convTrigB,
  input wire [NOUT:0] ovfIrq,
  input wire irqAny
);
  // ------------------------------------------------------------
  // Clocking and bus sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // Bus steps: request taken, then answered
  sequence wrTake;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence wrAns;
    s_axi_awready && s_axi_wready && s_axi_bvalid;
  endsequence
  sequence rdTake;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  sequence rdAns;
    s_axi_arready && s_axi_rvalid;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  write_answer_a: assert property (wrTake |=> wrAns)
    else $error("write not answered one cycle after it was taken");
  read_answer_a: assert property (rdTake |=> rdAns)
    else $error("read not answered one cycle after it was taken");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before bready");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  ready_pulse_a: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
    else $error("address and data ready not a joint single pulse");
  trig_a_follow_a: assert property ($stable(pwmOut[8]) |-> convTrigA == pwmOut[8])
    else $error("trigger A differs from output eight");
  trig_b_follow_a: assert property ($stable(pwmOut[9]) |-> convTrigB == pwmOut[9])
    else $error("trigger B differs from output nine");
  irq_any_or_a: assert property ($stable(|ovfIrq) |-> irqAny == (|ovfIrq))
    else $error("summary interrupt differs from the channel interrupts");
  // An interrupt only goes away through a register write
  irq_fall_sw_a: assert property ((($past(ovfIrq) & ~ovfIrq) != 0) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt fell without a register write");
endmodule // pwm_gen_properties

// [dv/tb_multi_channel_pwm_generator.sv]
// Purpose: self-checking bench for the multi-channel PWM unit
// Assumes: AXI4-Lite master tasks, stimulus by NBA at the rising edge
// Notes: period and duty expected from integer formulas of the settings
`timescale 1ns/10ps
`include "pwm_regs.vh"
module tb_multi_channel_pwm_generator;
  localparam logic [1:0] respOk = `PWM_RESP_OKAY;
  logic mclk = 0, reset_n = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] pwmOut;
  logic [10:0] ovfIrq;
  logic convTrigA, convTrigB, irqAny;
  int n_fail = 0, compares = 0, trigCntA, trigCntB;
  int irqCh [4] = '{0, 5, 8, 10};
  // ------------------------------------------------------------
  // Clock, design and far side
  // ------------------------------------------------------------
  always #50 mclk = ~mclk;
  multi_channel_pwm_generator i_multi_channel_pwm_generator (
    .mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pwmOut(pwmOut),
    .convTrigA(convTrigA), .convTrigB(convTrigB), .ovfIrq(ovfIrq), .irqAny(irqAny));
  conv_seq_model i_conv_seq_model (.mclk(mclk), .reset_n(reset_n), .convTrigA(convTrigA),
    .convTrigB(convTrigB), .trigCntA(trigCntA), .trigCntB(trigCntB));
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input string nm);
    n_fail++;
    $display("unexpected wait %s expected done seen hang", nm);
    final_report();
  endtask
  function automatic logic [7:0] ca(input int ch, input int f);
    return 8'(16 + 16 * ch + 4 * f);
  endfunction
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit aw = 0, w = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      aw = aw | (s_axi_awready === 1'b1);
      w = w | (s_axi_wready === 1'b1);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (aw && w && s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 40) tmo("write");
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 40) tmo("read");
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rdata", e, d);
    chk("rresp", er, r);
  endtask
  task automatic setup(input int ch, input int s, input int p, input int c, input int pol,
      input int dis);
    wr(ca(ch, 0), s, respOk);
    wr(ca(ch, 1), p, respOk);
    wr(ca(ch, 2), c, respOk);
    wr(ca(ch, 3), dis * 2 + pol, respOk);
  endtask
  // One full period between rising edges, with its high cycles
  task automatic meas(input int ch, output int hi, output int per);
    int n;
    logic prev = 1'b1;
    hi = 0;
    for (n = 0; n < 3000; n++) begin
      @(posedge mclk);
      if (pwmOut[ch] === 1'b1 && prev === 1'b0) break;
      prev = pwmOut[ch];
    end
    if (n == 3000) tmo("edge");
    for (per = 1; per < 3000; per++) begin
      hi += (pwmOut[ch] === 1'b1);
      prev = pwmOut[ch];
      @(posedge mclk);
      if (pwmOut[ch] === 1'b1 && prev === 1'b0) break;
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int k, s, p, c, hi, per, ch, m, b;
    logic [7:0] pa;
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'h0000_aaaa));
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk("pwmOut", 0, pwmOut);
    chk("ovfIrq", 0, ovfIrq);
    rdc(`PWM_CTRL_OFS, 0, respOk);
    rdc(ca(0, 1), 32'h0000_ffff, respOk);
    rdc(ca(10, 2), 0, respOk);
    for (k = 0; k < 3; k++) rdc(8'(4 + 4 * k), 0, respOk);
    rdc(8'hf0, 0, `PWM_RESP_SLVERR);
    wr(8'hf4, 32'h0000_ffff, `PWM_RESP_SLVERR);
    wr(ca(7, 0), 32'hffff_ffff, respOk);
    rdc(ca(7, 0), 32'h0000_03ff, respOk);
    wr(ca(7, 1), 32'hffff_ffff, respOk);
    rdc(ca(7, 1), 32'h0000_ffff, respOk);
    s_axi_wstrb <= 4'h1;
    wr(ca(7, 1), 32'h0000_1234, respOk);
    s_axi_wstrb <= 4'hf;
    rdc(ca(7, 1), 32'h0000_ff34, respOk);
    $display("test reset and map done");
    // Random settings, both polarities
    for (k = 0; k < 4; k++) begin
      ch = 3 * k;
      s = $urandom_range(2);
      p = $urandom_range(9, 2);
      c = $urandom_range(p, 1);
      setup(ch, s, p, c, k % 2, 0);
      wr(`PWM_CTRL_OFS, 1 << ch, respOk);
      meas(ch, hi, per);
      chk("period", (p + 1) * (s + 1), per);
      chk("high", (k % 2) ? (p + 1 - c) * (s + 1) : c * (s + 1), hi);
    end
    chk("trigB", 1, trigCntB != 0);
    wr(`PWM_CTRL_OFS, 0, respOk);
    $display("test waveform done");
    for (k = 0; k < 2; k++) begin
      setup(1, 0, 3, 1, 0, k);
      repeat (4) @(posedge mclk);
      chk("disLevel", k, pwmOut[1]);
    end
    $display("test disabled level done");
    setup(10, 0, 5, 2, 0, 0);
    setup(2, 0, 3, 1, 0, 1);
    wr(`PWM_CTRL_OFS, 1 << 10, respOk);
    meas(4, hi, per);
    chk("sharedPeriod", 6, per);
    chk("sharedHigh", 2, hi);
    for (k = 0; k < 8; k++) begin
      @(posedge mclk);
      chk("sharedAll", {10{pwmOut[0]}}, pwmOut);
    end
    wr(`PWM_CTRL_OFS, 0, respOk);
    repeat (4) @(posedge mclk);
    chk("ownLevel", 10'h006, pwmOut);
    rdc(`PWM_OUTSTAT_OFS, 32'h0000_0006, respOk);
    $display("test shared channel done");
    // Pending, mask and write-one-to-clear, channel five masked
    foreach (irqCh[i]) begin
      ch = irqCh[i];
      m = (ch != 5);
      pa = 8'(4 + 4 * (ch / 4));
      b = ch % 4;
      setup(ch, 0, 3, 1, 0, 0);
      wr(`PWM_CTRL_OFS, (1 << ch) | (m << (16 + ch)), respOk);
      for (k = 0; k < 20; k++) begin
        rd(pa, d, r);
        if (d[b] === 1'b1) break;
      end
      chk("pending", 1, d[b]);
      chk("ovfIrq", m, ovfIrq[ch]);
      chk("irqAny", m, irqAny);
      wr(`PWM_CTRL_OFS, m << (16 + ch), respOk);
      wr(pa, 0, respOk);
      rd(pa, d, r);
      chk("pendKept", 1, d[b]);
      wr(pa, 1 << b, respOk);
      rd(pa, d, r);
      chk("pendClear", 0, d[b]);
      chk("ovfIrqClear", 0, ovfIrq[ch]);
    end
    chk("trigA", 1, trigCntA != 0);
    $display("test interrupts done");
    final_report();
  end
endmodule // tb_multi_channel_pwm_generator
bind multi_channel_pwm_generator pwm_gen_properties #(.NOUT(NOUT)) i_pwm_gen_properties (
  .mclk(mclk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pwmOut(pwmOut), .convTrigA(convTrigA),
  .convTrigB(convTrigB), .ovfIrq(ovfIrq), .irqAny(irqAny));
